// >>> tb_three_phase_deadtime_pwm_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "tpdpwm_defines.vh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
   bad_count++; $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module tb_three_phase_deadtime_pwm_timer;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic [15:0] avs_address = 16'h0000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   wire [31:0] avs_readdata;
   wire avs_waitrequest;
   wire [5:0] drive;
   wire [5:0] gate;
   wire oe, uirq, tirq_a, tirq_b, shoot;
   int bad_count = 0;
   int check_count = 0;
   logic [31:0] rdat;
   int n, m, k;
   tpdpwm_timer uut (.ref_clk(ref_clk), .nrst(nrst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .pwm_out_u_pos(drive[0]),
      .pwm_out_u_neg(drive[1]), .pwm_out_v_pos(drive[2]),
      .pwm_out_v_neg(drive[3]), .pwm_out_w_pos(drive[4]),
      .pwm_out_w_neg(drive[5]), .pwm_out_oe(oe), .underflow_irq(uirq),
      .trigger_irq_a(tirq_a), .trigger_irq_b(tirq_b));
   tpdpwm_gate_model gm (.drive(drive), .oe(oe), .gate(gate),
      .shoot(shoot));
   initial forever #12.5 ref_clk = ~ref_clk;
   function automatic logic [15:0] cmp(input int i);
      return 16'(`TPDPWM_CMP_BASE + 4 * i);
   endfunction
   function automatic logic [15:0] shd(input int i);
      return 16'(`TPDPWM_SHD_BASE + 4 * i);
   endfunction
   task automatic bus(input logic rd, input logic [15:0] a,
         input logic [31:0] d, input logic [3:0] be);
      logic w;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_read <= rd;
      avs_write <= !rd;
      do begin
         @(negedge ref_clk);
         w = avs_waitrequest;
         rdat = avs_readdata;
         @(posedge ref_clk);
      end while (w !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      bus(1'b0, a, d, 4'hf);
   endtask
   task automatic rchk(input string nm, input logic [15:0] a,
         input logic [31:0] e);
      bus(1'b1, a, 32'h0, 4'hf);
      `CHK(nm, e, rdat)
   endtask
   // Cycles and trigger pulses up to the next divided underflow
   task automatic wait_irq(output int c, output int t);
      c = 0;
      t = 0;
      k = 0;
      do begin
         @(negedge ref_clk);
         c++;
         t += (tirq_a === 1'b1);
         k += (tirq_b === 1'b1);
      end while (uirq !== 1'b1);
   endtask
   // Cycles from u pos falling until u neg rises
   task automatic gap(output int c);
      while (gate[0] !== 1'b1) @(negedge ref_clk);
      while (gate[0] !== 1'b0) @(negedge ref_clk);
      c = 0;
      do begin
         @(negedge ref_clk);
         c++;
      end while (gate[1] !== 1'b1);
   endtask
   task automatic t_reset_values;
      `CHK("float", 6'h00, gate)
      rchk("control", `TPDPWM_CTRL_ADDR, 32'h00);
      rchk("dt reload", `TPDPWM_DT_ADDR, 32'hff);
      rchk("unmapped", 16'hff84, 32'h0);
      for (int i = 0; i < 6; i++) begin
         rchk("compare", cmp(i), i == 3 ? 32'h0ff : 32'h0);
         rchk("shadow", shd(i), i == 3 ? 32'h0ff : 32'h0);
      end
   endtask
   task automatic t_stopped_writes;
      wr(`TPDPWM_CTRL_ADDR, 32'h40);
      rchk("ctrl bit6", `TPDPWM_CTRL_ADDR, 32'h00);
      wr(cmp(3), 32'h4);
      wr(shd(3), 32'h4);
      wr(`TPDPWM_DT_ADDR, 32'h0);
      wr(cmp(0), 32'h2);
      wr(shd(0), 32'h2);
      wr(cmp(4), 32'h3);
      wr(shd(4), 32'h3);
      wr(cmp(5), 32'h1);
      wr(shd(5), 32'h1);
      rchk("cmp u", cmp(0), 32'h2);
      wr(shd(1), 32'h3ff);
      bus(1'b0, shd(1), 32'h55, 4'h1);
      rchk("low byte", shd(1), 32'h355);
   endtask
   task automatic t_running;
      wr(`TPDPWM_CTRL_ADDR, 32'h80);
      gap(n);
      `CHK("dead time", 1, n)
      `CHK("leg short", 1'b0, shoot)
      wait_irq(n, m);
      wait_irq(n, m);
      `CHK("period", 8, n)
      `CHK("trig count", 2, m)
      `CHK("trig b count", 2, k)
      @(negedge ref_clk);
      `CHK("v w legs", 4'ha, gate[5:2])
      wr(`TPDPWM_DT_ADDR, 32'h5);
      rchk("dt locked", `TPDPWM_DT_ADDR, 32'h0);
      wr(cmp(3), 32'h9);
      rchk("cmp locked", cmp(3), 32'h4);
      wr(shd(3), 32'h6);
      rchk("shd live", shd(3), 32'h6);
      wait_irq(n, m);
      wait_irq(n, m);
      `CHK("new period", 12, n)
      rchk("cmp loaded", cmp(3), 32'h6);
      wr(`TPDPWM_CTRL_ADDR, 32'h00);
      @(negedge ref_clk);
      `CHK("stopped", 6'h00, gate)
      `CHK("stop drive", 6'h00, drive)
      rchk("u cleared", cmp(0), 32'h0);
      rchk("trig cleared", cmp(4), 32'h0);
   endtask
   task automatic t_clock_divide;
      for (int i = 0; i < 7; i++) begin
         wr(`TPDPWM_CTRL_ADDR, 32'h80 | (i << 3) | i);
         wait_irq(n, m);
         wait_irq(n, m);
         `CHK("irq gap", (12 << (i > 5 ? 5 : i)) * (i + 1), n)
         `CHK("trig count", 2 * (i + 1), m)
         `CHK("trig b count", 2 * (i + 1), k)
         wr(`TPDPWM_CTRL_ADDR, 32'h00);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge ref_clk);
      bad_count++;
      give_verdict();
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      t_reset_values();
      t_stopped_writes();
      t_running();
      t_clock_divide();
      give_verdict();
   end
endmodule
`default_nettype wire

// >>> tpdpwm_chk.sv
`timescale 1ns/10ps
`default_nettype none
module tpdpwm_chk (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Register bus
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   // Gate outputs
   input wire logic pwm_out_u_pos,
   input wire logic pwm_out_u_neg,
   input wire logic pwm_out_v_pos,
   input wire logic pwm_out_v_neg,
   input wire logic pwm_out_w_pos,
   input wire logic pwm_out_w_neg,
   input wire logic pwm_out_oe,
   // Interrupt requests
   input wire logic underflow_irq,
   input wire logic trigger_irq_a,
   input wire logic trigger_irq_b
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   sequence s_req_start;
      $rose(avs_read | avs_write);
   endsequence
   sequence s_one_wait;
      avs_waitrequest ##1 !avs_waitrequest;
   endsequence
   a_one_wait: assert property (s_req_start |-> s_one_wait)
      else $error("bus access did not take one wait cycle");
   a_idle_nowait: assert property (!(avs_read | avs_write) |->
      !avs_waitrequest) else $error("waitrequest while idle");
   a_float_quiet: assert property (!pwm_out_oe |->
      !(pwm_out_u_pos | pwm_out_u_neg | pwm_out_v_pos | pwm_out_v_neg |
      pwm_out_w_pos | pwm_out_w_neg)) else $error("drive while floating");
   a_no_overlap: assert property (!(pwm_out_u_pos & pwm_out_u_neg) &&
      !(pwm_out_v_pos & pwm_out_v_neg) && !(pwm_out_w_pos & pwm_out_w_neg))
      else $error("both gates of a leg on");
   a_gap_upos: assert property ($rose(pwm_out_u_pos) |->
      !$past(pwm_out_u_neg)) else $error("no dead time before u pos");
   a_gap_vneg: assert property ($rose(pwm_out_v_neg) |->
      !$past(pwm_out_v_pos)) else $error("no dead time before v neg");
   a_irq_pulse: assert property (underflow_irq |=> !underflow_irq)
      else $error("underflow irq longer than one cycle");
   a_irq_running: assert property (underflow_irq |-> $past(pwm_out_oe))
      else $error("underflow irq while stopped");
   a_trig_pulse: assert property (trigger_irq_a |=> !trigger_irq_a)
      else $error("trigger a longer than one cycle");
   a_trig_running: assert property ((trigger_irq_a | trigger_irq_b) |->
      $past(pwm_out_oe)) else $error("trigger irq while stopped");
endmodule
bind tpdpwm_timer tpdpwm_chk u_chk (.ref_clk, .nrst, .avs_read, .avs_write,
   .avs_waitrequest, .pwm_out_u_pos, .pwm_out_u_neg, .pwm_out_v_pos,
   .pwm_out_v_neg, .pwm_out_w_pos, .pwm_out_w_neg, .pwm_out_oe,
   .underflow_irq, .trigger_irq_a, .trigger_irq_b);
`default_nettype wire

// >>> tpdpwm_defines.vh
`ifndef TPDPWM_DEFINES_VH
`define TPDPWM_DEFINES_VH

// Byte addresses on the register bus
`define TPDPWM_CTRL_ADDR 16'hff88
`define TPDPWM_DT_ADDR 16'hff90
`define TPDPWM_CMP_BASE 16'hffc0
`define TPDPWM_SHD_BASE 16'hffe0
`define TPDPWM_BLK_HI 15
`define TPDPWM_BLK_LO 5
`define TPDPWM_IDX_HI 4
`define TPDPWM_IDX_LO 2
`define TPDPWM_NUM_CMP 3'h6
`define TPDPWM_CMP_BLK 11'h7fe
`define TPDPWM_SHD_BLK 11'h7ff

// Control register fields
`define TPDPWM_RUN_BIT 7
`define TPDPWM_SEL_HI 5
`define TPDPWM_SEL_LO 3
`define TPDPWM_DIV_HI 2
`define TPDPWM_DIV_LO 0
`define TPDPWM_SEL_MAX 3'h5

// Reset and idle values
`define TPDPWM_CTRL_RST 8'h00
`define TPDPWM_PERIOD_IDX 3
`define TPDPWM_PERIOD_RST 10'h0ff
`define TPDPWM_CMP_RST 10'h000
`define TPDPWM_DT_RST 8'hff
`define TPDPWM_DTM_IDLE 8'hff
`define TPDPWM_DTM_ZERO 8'h00
`define TPDPWM_DIV_RST 3'h7
`define TPDPWM_CNT_ZERO 10'h000
`define TPDPWM_CNT_ONE 10'h001

`endif

// >>> tpdpwm_gate_model.sv
`timescale 1ns/10ps
`default_nettype none
module tpdpwm_gate_model (
   // Gate drive from the timer
   input wire logic [5:0] drive,
   input wire logic oe,
   // Resolved gate levels
   output logic [5:0] gate,
   output logic shoot
);
   // Pull-downs keep every switch off while the pins float
   assign gate = oe ? drive : 6'h00;
   // Both switches of one leg on would short the supply
   assign shoot = (gate[0] & gate[1]) | (gate[2] & gate[3]) |
      (gate[4] & gate[5]);
endmodule
`default_nettype wire

// >>> tpdpwm_timer.v
// Summary of operation
// - After start the counter counts up from zero until it matches period.
// - Counting down, reaching zero gives underflow, then counting turns up.
// - Direction change at period or zero applies on the next count tick.
// - Clock select 0..5 divides system clock by 1 to 32; 6, 7 forbidden.
// - Run enable low clears and stops timers; all six outputs float.
// - Reset or run enable clear sets the counter to zero.
// - Counter, dead-time timers and divider have no software access.
// - Phase compares watch the counter; a match updates that phase flop.
// - Divided underflow interrupt copies every shadow into its compare.
// - Compare writes only land while stopped; running uses shadows.
// - Shadows are readable and writable anytime, word or low byte.
// - Period and its shadow reset 0FFH, others zero; stop zeros compares except period.
// - Trigger compares watch the counter; each match raises its request.
// - One dead-time reload value, loaded by each timer at its own match.
// - Dead-time reload writes are dropped while the counter runs.
// - Dead-time reload resets FFH; zero still gives one clock dead time.
// - Dead-time timer reloads on match, counts down, stops at FFH.
// - Divider counts underflows, fires on match, then returns to 7H.
// - Divide setting N yields one interrupt per N plus one underflows.
// - Control resets zero: run bit 7, clock select 5:3, divide 2:0.
// - Dead time equals reload plus one system clock periods.
`timescale 1ns/10ps
`default_nettype none
`include "tpdpwm_defines.vh"

module tpdpwm_timer (
   // Clock and reset
   input wire ref_clk,
   input wire nrst,
   // Avalon-MM slave
   input wire [15:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output wire avs_waitrequest,
   // Inverter gate outputs
   output reg pwm_out_u_pos,
   output reg pwm_out_u_neg,
   output reg pwm_out_v_pos,
   output reg pwm_out_v_neg,
   output reg pwm_out_w_pos,
   output reg pwm_out_w_neg,
   output wire pwm_out_oe,
   // Interrupt requests
   output reg underflow_irq,
   output reg trigger_irq_a,
   output reg trigger_irq_b
);

   reg rst_a_ff;
   reg rst_n_ff;
   wire rst_n;

   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rst_a_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end else begin
         rst_a_ff <= 1'b1;
         rst_n_ff <= rst_a_ff;
      end
   end
   assign rst_n = rst_n_ff;

   // Bus handshake: one wait cycle per access
   reg ack_ff;
   wire req;
   wire wr_en;

   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_ff;
   assign wr_en = avs_write & ack_ff;

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req & ~ack_ff;
      end
   end

   wire hit_ctrl;
   wire hit_dt;
   wire hit_cmp;
   wire hit_shd;
   wire [2:0] idx;

   assign idx = avs_address[`TPDPWM_IDX_HI:`TPDPWM_IDX_LO];
   assign hit_ctrl = avs_address == `TPDPWM_CTRL_ADDR;
   assign hit_dt = avs_address == `TPDPWM_DT_ADDR;
   // Aligned word slots only; sub-word offsets read zero
   assign hit_cmp = (avs_address[`TPDPWM_BLK_HI:`TPDPWM_BLK_LO] ==
      `TPDPWM_CMP_BLK) &&
      (idx < `TPDPWM_NUM_CMP) &&
      (avs_address[1:0] == 2'h0);
   assign hit_shd = (avs_address[`TPDPWM_BLK_HI:`TPDPWM_BLK_LO] ==
      `TPDPWM_SHD_BLK) &&
      (idx < `TPDPWM_NUM_CMP) &&
      (avs_address[1:0] == 2'h0);

   // Control and dead-time reload
   reg [7:0] ctrl_ff;
   reg [7:0] dt_reload_ff;
   reg run_prev_ff;
   wire run;
   wire run_clr;
   wire stop_wr;
   wire [2:0] sel;
   wire [2:0] div_set;

   assign run = ctrl_ff[`TPDPWM_RUN_BIT];
   assign sel = ctrl_ff[`TPDPWM_SEL_HI:`TPDPWM_SEL_LO];
   assign div_set = ctrl_ff[`TPDPWM_DIV_HI:`TPDPWM_DIV_LO];
   assign run_clr = run_prev_ff & ~run;
   assign pwm_out_oe = run;
   // Stop write clears the drive flops on the same edge as the run bit
   assign stop_wr = wr_en && hit_ctrl && avs_byteenable[0] &&
      !avs_writedata[`TPDPWM_RUN_BIT];

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff <= `TPDPWM_CTRL_RST;
         dt_reload_ff <= `TPDPWM_DT_RST;
         run_prev_ff <= 1'b0;
      end else begin
         run_prev_ff <= run;
         if (wr_en && hit_ctrl && avs_byteenable[0]) begin
            // Bit 6 is not stored and reads zero
            ctrl_ff <= avs_writedata[7:0] & 8'hbf;
         end
         if (wr_en && hit_dt && avs_byteenable[0] && !run) begin
            dt_reload_ff <= avs_writedata[7:0];
         end
      end
   end

   // Count clock prescaler
   reg [4:0] pre_ff;
   wire [2:0] sel_eff;
   wire [5:0] sel_sh;
   wire [5:0] sel_m6;
   wire [4:0] sel_mask;
   wire tick;

   // Forbidden codes fall back to the slowest rate
   assign sel_eff = (sel > `TPDPWM_SEL_MAX) ? `TPDPWM_SEL_MAX : sel;
   assign sel_sh = 6'h01 << sel_eff;
   assign sel_m6 = sel_sh - 6'h01;
   assign sel_mask = sel_m6[4:0];
   assign tick = run && ((pre_ff & sel_mask) == sel_mask);

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_ff <= 5'h00;
      end else if (!run) begin
         pre_ff <= 5'h00;
      end else begin
         pre_ff <= pre_ff + 5'h01;
      end
   end

   // Up/down counter, internal only
   reg [9:0] updown_counter_ff;
   reg up_ff;
   reg uf_ff;
   reg tick_d_ff;
   wire [9:0] period;

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         updown_counter_ff <= `TPDPWM_CNT_ZERO;
         up_ff <= 1'b1;
         uf_ff <= 1'b0;
         tick_d_ff <= 1'b0;
      end else if (!run) begin
         updown_counter_ff <= `TPDPWM_CNT_ZERO;
         up_ff <= 1'b1;
         uf_ff <= 1'b0;
         tick_d_ff <= 1'b0;
      end else begin
         tick_d_ff <= tick;
         uf_ff <= tick && !up_ff &&
            updown_counter_ff == `TPDPWM_CNT_ONE;
         if (tick) begin
            if (up_ff) begin
               if (updown_counter_ff == period) begin
                  up_ff <= 1'b0;
                  updown_counter_ff <= updown_counter_ff - 10'h001;
               end else begin
                  updown_counter_ff <= updown_counter_ff + 10'h001;
               end
            end else begin
               if (updown_counter_ff == `TPDPWM_CNT_ZERO) begin
                  up_ff <= 1'b1;
                  updown_counter_ff <= updown_counter_ff + 10'h001;
               end else begin
                  updown_counter_ff <= updown_counter_ff - 10'h001;
               end
            end
         end
      end
   end

   // Underflow interrupt divider
   reg [2:0] underflow_divider_counter_ff;
   wire [2:0] nxt_div;
   wire irq_now;

   assign nxt_div = underflow_divider_counter_ff + 3'h1;
   assign irq_now = uf_ff && (nxt_div == div_set);

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         underflow_divider_counter_ff <= `TPDPWM_DIV_RST;
         underflow_irq <= 1'b0;
      end else if (!run) begin
         underflow_divider_counter_ff <= `TPDPWM_DIV_RST;
         underflow_irq <= 1'b0;
      end else begin
         underflow_irq <= irq_now;
         if (irq_now) begin
            underflow_divider_counter_ff <= `TPDPWM_DIV_RST;
         end else if (uf_ff) begin
            underflow_divider_counter_ff <= nxt_div;
         end
      end
   end

   // Compare registers and their shadows
   reg [9:0] cmp_ff [0:5];
   reg [9:0] shd_ff [0:5];
   wire [5:0] match;

   assign period = cmp_ff[`TPDPWM_PERIOD_IDX];

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi = gi + 1) begin : g_cmp
         localparam [9:0] RST_V = (gi == `TPDPWM_PERIOD_IDX) ?
            `TPDPWM_PERIOD_RST : `TPDPWM_CMP_RST;
         localparam CLR_ON_STOP = (gi != `TPDPWM_PERIOD_IDX);
         wire sel_me;

         assign sel_me = wr_en && (idx == gi[2:0]);
         // Gated by run so a match cannot outlive a stop
         assign match[gi] = run && tick_d_ff &&
            (updown_counter_ff == cmp_ff[gi]);

         always @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               shd_ff[gi] <= RST_V;
            end else if (sel_me && hit_shd) begin
               // Any time, per byte lane
               if (avs_byteenable[0]) begin
                  shd_ff[gi][7:0] <= avs_writedata[7:0];
               end
               if (avs_byteenable[1]) begin
                  shd_ff[gi][9:8] <= avs_writedata[9:8];
               end
            end
         end

         always @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               cmp_ff[gi] <= RST_V;
            end else if (sel_me && hit_cmp && !run) begin
               if (avs_byteenable[0]) begin
                  cmp_ff[gi][7:0] <= avs_writedata[7:0];
               end
               if (avs_byteenable[1]) begin
                  cmp_ff[gi][9:8] <= avs_writedata[9:8];
               end
            end else if (run_clr && CLR_ON_STOP) begin
               cmp_ff[gi] <= `TPDPWM_CMP_RST;
            end else if (irq_now) begin
               cmp_ff[gi] <= shd_ff[gi];
            end
         end
      end
   endgenerate

   // Trigger requests, one cycle each
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         trigger_irq_a <= 1'b0;
         trigger_irq_b <= 1'b0;
      end else begin
         trigger_irq_a <= match[4];
         trigger_irq_b <= match[5];
      end
   end

   // Per-phase flop, dead-time timer and output pair
   reg [2:0] phase_ff;
   reg [2:0] busy_ff;
   reg [7:0] dtm_ff [0:2];
   reg [2:0] pos_ff;
   reg [2:0] neg_ff;

   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_phase
         wire gap;

         // Gap covers load cycle plus reload value counts
         assign gap = match[gi] ||
            (busy_ff[gi] && dtm_ff[gi] != `TPDPWM_DTM_ZERO);

         always @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               phase_ff[gi] <= 1'b0;
               busy_ff[gi] <= 1'b0;
               dtm_ff[gi] <= `TPDPWM_DTM_IDLE;
               pos_ff[gi] <= 1'b0;
               neg_ff[gi] <= 1'b0;
            end else if (!run || stop_wr) begin
               phase_ff[gi] <= 1'b0;
               busy_ff[gi] <= 1'b0;
               dtm_ff[gi] <= `TPDPWM_DTM_IDLE;
               pos_ff[gi] <= 1'b0;
               neg_ff[gi] <= 1'b0;
            end else begin
               if (match[gi]) begin
                  // Positive side active above the compare level
                  phase_ff[gi] <= up_ff;
                  dtm_ff[gi] <= dt_reload_ff;
                  busy_ff[gi] <= 1'b1;
               end else if (busy_ff[gi]) begin
                  dtm_ff[gi] <= dtm_ff[gi] - 8'h01;
                  if (dtm_ff[gi] == `TPDPWM_DTM_ZERO) begin
                     busy_ff[gi] <= 1'b0;
                  end
               end
               pos_ff[gi] <= phase_ff[gi] & ~gap;
               neg_ff[gi] <= ~phase_ff[gi] & ~gap;
            end
         end
      end
   endgenerate

   always @* begin
      pwm_out_u_pos = pos_ff[0];
      pwm_out_u_neg = neg_ff[0];
      pwm_out_v_pos = pos_ff[1];
      pwm_out_v_neg = neg_ff[1];
      pwm_out_w_pos = pos_ff[2];
      pwm_out_w_neg = neg_ff[2];
   end

   // Read path; internal counters are not mapped
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read && !ack_ff) begin
         if (hit_ctrl) begin
            avs_readdata <= {24'h000000, ctrl_ff};
         end else if (hit_dt) begin
            avs_readdata <= {24'h000000, dt_reload_ff};
         end else if (hit_cmp) begin
            avs_readdata <= {22'h0, cmp_ff[idx]};
         end else if (hit_shd) begin
            avs_readdata <= {22'h0, shd_ff[idx]};
         end else begin
            avs_readdata <= 32'h00000000;
         end
      end
   end

endmodule
`default_nettype wire
